// File: hdl/pcb_cfg_pkg.sv
// Constants, field layouts and enumerations shared by the power, clock and buffer configuration block.
package pcb_cfg_pkg;

  // Register addresses carried in the serial header.
  localparam logic [6:0] ADDR_POWER_CLOCK    = 7'h15;
  localparam logic [6:0] ADDR_ANALOG_BUFFER  = 7'h16;

  // Values after reset and special values.
  localparam logic [7:0] POWER_CLOCK_RESET   = 8'h00;
  localparam logic [7:0] ANALOG_BUFFER_RESET = 8'h00;
  localparam logic [7:0] POWER_DOWN_ONLY     = 8'h08;
  localparam logic [7:0] POWER_DOWN_MASK     = 8'h08;
  localparam logic [7:0] ANALOG_BUFFER_WMASK = 8'hf3;
  localparam logic [7:0] UNMAPPED_READ       = 8'h00;

  // Field positions of the power and clock register.
  localparam int CLK_SEL_HI   = 7;
  localparam int CLK_SEL_LO   = 6;
  localparam int DIV_SEL_HI   = 5;
  localparam int DIV_SEL_LO   = 4;
  localparam int PWR_DOWN_BIT = 3;
  localparam int RAW_MOD_BIT  = 2;
  localparam int PWR_LVL_HI   = 1;
  localparam int PWR_LVL_LO   = 0;

  // Field positions of the analog buffer register.
  localparam int REF_POS_HI   = 7;
  localparam int REF_POS_LO   = 6;
  localparam int REF_NEG_HI   = 5;
  localparam int REF_NEG_LO   = 4;
  localparam int AIN_POS_BIT  = 1;
  localparam int AIN_NEG_BIT  = 0;

  // Serial frame layout: read flag, 7 address bits, 8 data bits.
  localparam int         FRAME_BITS     = 16;
  localparam logic [3:0] HEADER_LAST    = 4'h7;
  localparam logic [3:0] FRAME_LAST     = 4'hf;
  localparam logic [15:0] RESUME_WORD   = 16'ha55a;

  // Number of synchronised pins and pin order in the synchroniser vector.
  localparam int SYNC_PINS = 4;
  localparam int PIN_CS_N  = 0;
  localparam int PIN_SCLK  = 1;
  localparam int PIN_SDI   = 2;
  localparam int PIN_RST_N = 3;
  // Idle pin levels loaded at reset, so that no false serial clock edge follows reset.
  localparam logic [SYNC_PINS-1:0] SYNC_IDLE = 4'h9;

  // Half periods of the modulator clock, in master clock cycles.
  localparam logic [3:0] HALF_DIV16 = 4'h8;
  localparam logic [3:0] HALF_DIV8  = 4'h4;
  localparam logic [3:0] HALF_DIV4  = 4'h2;
  localparam logic [3:0] HALF_DIV2  = 4'h1;

  typedef enum logic [1:0] {
    CLK_CMOS = 2'b00,
    CLK_XTAL = 2'b01,
    CLK_LVDS = 2'b10,
    CLK_RC   = 2'b11
  } clock_source_t;

  typedef enum logic [1:0] {
    DIV_16 = 2'b00,
    DIV_8  = 2'b01,
    DIV_4  = 2'b10,
    DIV_2  = 2'b11
  } mod_divide_t;

  typedef enum logic [1:0] {
    PWR_LOW    = 2'b00,
    PWR_MEDIAN = 2'b10,
    PWR_FAST   = 2'b11
  } core_power_t;

  typedef enum logic [1:0] {
    REF_PRECHARGE  = 2'b00,
    REF_UNBUFFERED = 2'b01,
    REF_FULL       = 2'b10
  } ref_buffering_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_HEADER = 3'b001,
    ST_DATA   = 3'b010,
    ST_WAIT   = 3'b011,
    ST_OFF    = 3'b100
  } frame_state_t;

endpackage

// File: hdl/mod_div_if.sv
// Interface between the configuration logic and the modulator clock divider.
`timescale 1ns/100ps
interface mod_div_if;
  logic [1:0] div_sel;
  logic       run;
  logic       mod_clk;

  modport ctrl (output div_sel, output run, input mod_clk);
  modport div  (input div_sel, input run, output mod_clk);
endinterface

// File: hdl/mod_clock_divider.sv
// Divider that makes the modulator clock from the master clock.
`timescale 1ns/100ps
module mod_clock_divider (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Divider control and output
  mod_div_if.div   dif
);

  function automatic logic [3:0] half_period(input logic [1:0] sel);
    case (sel)
      pcb_cfg_pkg::DIV_16: half_period = pcb_cfg_pkg::HALF_DIV16;
      pcb_cfg_pkg::DIV_8:  half_period = pcb_cfg_pkg::HALF_DIV8;
      pcb_cfg_pkg::DIV_4:  half_period = pcb_cfg_pkg::HALF_DIV4;
      default:             half_period = pcb_cfg_pkg::HALF_DIV2;
    endcase
  endfunction

  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic       mod_clk_reg;
  logic       mod_clk_next;

  // A shorter divide chosen mid-period ends the current half at once rather than wrapping.
  wire  [3:0] half_w   = half_period(dif.div_sel);
  wire        at_end_w = (count_reg >= (half_w - 4'h1));

  assign count_next   = (!dif.run || at_end_w) ? 4'h0 : (count_reg + 4'h1);
  assign mod_clk_next = !dif.run ? 1'b0 : (at_end_w ? ~mod_clk_reg : mod_clk_reg);
  assign dif.mod_clk  = mod_clk_reg;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      count_reg   <= 4'h0;
      mod_clk_reg <= 1'b0;
    end else begin
      count_reg   <= count_next;
      mod_clk_reg <= mod_clk_next;
    end
  end

  // A divide change aborts the check, since the phase in flight may then be cut short.
  AST_DIV16_HIGH: assert property (@(posedge sys_clk)
    disable iff (sys_rst || !dif.run || dif.div_sel != 2'b00)
    $rose(mod_clk_reg) |-> mod_clk_reg [*8] ##1 !mod_clk_reg)
    else $error("Divide by 16 high phase is not 8 cycles.");

  AST_DIV2_TOGGLE: assert property (@(posedge sys_clk) disable iff (sys_rst || !dif.run)
    ($past(dif.div_sel) == 2'b11 && $past(dif.run)) |-> (mod_clk_reg != $past(mod_clk_reg)))
    else $error("Divide by 2 clock does not toggle every cycle.");

endmodule

// File: hdl/power_clock_buffer_config.sv
// Power, clock and analog buffer configuration registers with their serial register port.
`timescale 1ns/100ps
// Summary of operation
// - Bits 7:6 pick the working clock source.
// - Bits 5:4 divide master clock by 16/8/4/2.
// - Power-down bit with others: whole write discarded.
// - Powered down: serial port ignores register transactions.
// - Exit power-down by reset pin, resume, power cycle.
// - Raw modulator output forces low power mode.
// - Bits 1:0 choose low, median or fast power.
// - Buffer bits 7:6 set positive reference buffering.
// - Buffer bits 5:4 set negative reference buffering.
// - Buffer bit 1 disables positive input precharge.
// - Buffer bit 0 disables negative input precharge.
// - Power and clock register at 0x15, resets 0x00.
// - Analog buffer register at 0x16, resets 0x00.
module power_clock_buffer_config (
  // Clock and power-on reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Hardware reset pin
  input  wire logic       reset_pin_n,
  // Serial register port
  input  wire logic       spi_cs_n,
  input  wire logic       spi_sclk,
  input  wire logic       spi_sdi,
  output logic            spi_sdo,
  output logic            spi_sdo_oe_n,
  // Clock configuration
  output logic [1:0]      clock_source,
  output logic            modulator_frequency,
  // Core power configuration
  output logic            powered_down,
  output logic            raw_modulator_out_enable,
  output logic [1:0]      core_power_level,
  // Analog buffer configuration
  output logic [1:0]      pos_reference_buffering,
  output logic [1:0]      neg_reference_buffering,
  output logic            pos_input_precharge_disable,
  output logic            neg_input_precharge_disable
);

  // Pin synchronisers: three stages, a change counts once stages two and three agree.
  logic [pcb_cfg_pkg::SYNC_PINS-1:0] stage1_reg;
  logic [pcb_cfg_pkg::SYNC_PINS-1:0] stage2_reg;
  logic [pcb_cfg_pkg::SYNC_PINS-1:0] stage3_reg;
  logic [pcb_cfg_pkg::SYNC_PINS-1:0] filt_reg;
  logic [pcb_cfg_pkg::SYNC_PINS-1:0] filt_next;
  wire  [pcb_cfg_pkg::SYNC_PINS-1:0] pins_w = {reset_pin_n, spi_sdi, spi_sclk, spi_cs_n};

  genvar gi;
  generate
    for (gi = 0; gi < pcb_cfg_pkg::SYNC_PINS; gi = gi + 1) begin : g_sync
      assign filt_next[gi] = (stage2_reg[gi] == stage3_reg[gi]) ? stage3_reg[gi] : filt_reg[gi];
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          stage1_reg[gi] <= pcb_cfg_pkg::SYNC_IDLE[gi];
          stage2_reg[gi] <= pcb_cfg_pkg::SYNC_IDLE[gi];
          stage3_reg[gi] <= pcb_cfg_pkg::SYNC_IDLE[gi];
          filt_reg[gi]   <= pcb_cfg_pkg::SYNC_IDLE[gi];
        end else begin
          stage1_reg[gi] <= pins_w[gi];
          stage2_reg[gi] <= stage1_reg[gi];
          stage3_reg[gi] <= stage2_reg[gi];
          filt_reg[gi]   <= filt_next[gi];
        end
      end
    end
  endgenerate

  // Register read decode.
  function automatic logic [7:0] read_value(input logic [6:0] addr,
                                            input logic [7:0] pwr,
                                            input logic [7:0] abuf);
    if (addr == pcb_cfg_pkg::ADDR_POWER_CLOCK) begin
      read_value = pwr;
    end else if (addr == pcb_cfg_pkg::ADDR_ANALOG_BUFFER) begin
      read_value = abuf;
    end else begin
      read_value = pcb_cfg_pkg::UNMAPPED_READ;
    end
  endfunction

  // Effective core power: raw modulator output overrides the field, and the unused code 01 means low.
  function automatic logic [1:0] core_level(input logic [7:0] pwr);
    if (pwr[pcb_cfg_pkg::RAW_MOD_BIT]) begin
      core_level = pcb_cfg_pkg::PWR_LOW;
    end else if (pwr[pcb_cfg_pkg::PWR_LVL_HI:pcb_cfg_pkg::PWR_LVL_LO] == pcb_cfg_pkg::PWR_FAST) begin
      core_level = pcb_cfg_pkg::PWR_FAST;
    end else if (pwr[pcb_cfg_pkg::PWR_LVL_HI:pcb_cfg_pkg::PWR_LVL_LO] == pcb_cfg_pkg::PWR_MEDIAN) begin
      core_level = pcb_cfg_pkg::PWR_MEDIAN;
    end else begin
      core_level = pcb_cfg_pkg::PWR_LOW;
    end
  endfunction

  pcb_cfg_pkg::frame_state_t state_reg;
  pcb_cfg_pkg::frame_state_t state_next;
  logic [15:0] shift_reg;
  logic [15:0] shift_next;
  logic [3:0]  bit_count_reg;
  logic [3:0]  bit_count_next;
  logic [7:0]  header_reg;
  logic [7:0]  header_next;
  logic [7:0]  out_shift_reg;
  logic [7:0]  out_shift_next;
  logic        sclk_prev_reg;
  logic [7:0]  power_clock_reg;
  logic [7:0]  power_clock_next;
  logic [7:0]  analog_buffer_reg;
  logic [7:0]  analog_buffer_next;
  logic [1:0]  core_power_reg;
  logic        sdo_reg;
  logic        sdo_next;
  logic        sdo_oe_n_reg;

  // Filtered pin views and edges.
  wire cs_active_w  = !filt_reg[pcb_cfg_pkg::PIN_CS_N];
  wire sclk_w       = filt_reg[pcb_cfg_pkg::PIN_SCLK];
  wire sclk_rise_w  = sclk_w && !sclk_prev_reg;
  wire sclk_fall_w  = !sclk_w && sclk_prev_reg;
  wire hw_reset_w   = !filt_reg[pcb_cfg_pkg::PIN_RST_N];
  wire [15:0] shift_in_w = {shift_reg[14:0], filt_reg[pcb_cfg_pkg::PIN_SDI]};

  // Frame decode.
  wire       is_read_w    = header_reg[7];
  wire [6:0] addr_w       = header_reg[6:0];
  wire       header_end_w = (state_reg == pcb_cfg_pkg::ST_HEADER) && sclk_rise_w && (bit_count_reg == pcb_cfg_pkg::HEADER_LAST);
  wire       frame_end_w  = (state_reg == pcb_cfg_pkg::ST_DATA) && sclk_rise_w && (bit_count_reg == pcb_cfg_pkg::FRAME_LAST);
  wire       commit_w     = frame_end_w && !is_read_w && cs_active_w;
  wire [7:0] wdata_w      = shift_in_w[7:0];
  wire       wr_power_w   = commit_w && (addr_w == pcb_cfg_pkg::ADDR_POWER_CLOCK);
  wire       wr_abuf_w    = commit_w && (addr_w == pcb_cfg_pkg::ADDR_ANALOG_BUFFER);

  // Power-down guard: the bit alone is accepted, mixed with any other bit the write is dropped.
  wire       pd_attempt_w = wdata_w[pcb_cfg_pkg::PWR_DOWN_BIT];
  wire       pd_exact_w   = (wdata_w == pcb_cfg_pkg::POWER_DOWN_ONLY);
  wire       power_ok_w   = wr_power_w && (!pd_attempt_w || pd_exact_w);
  wire       enter_off_w  = wr_power_w && pd_exact_w;

  // While raw modulator output is chosen the power mode field keeps its old contents.
  wire [7:0] power_value_w = wdata_w[pcb_cfg_pkg::RAW_MOD_BIT] ?
                             {wdata_w[7:2], power_clock_reg[1:0]} : wdata_w;

  // The resume pattern is heard on data and clock alone, chip select is not needed.
  wire       resume_hit_w = (state_reg == pcb_cfg_pkg::ST_OFF) && sclk_rise_w &&
                            (shift_in_w == pcb_cfg_pkg::RESUME_WORD);

  wire [7:0] read_data_w = read_value(shift_in_w[6:0], power_clock_reg, analog_buffer_reg);

  // Frame sequencing.
  always_comb begin
    state_next     = state_reg;
    shift_next     = shift_reg;
    bit_count_next = bit_count_reg;
    header_next    = header_reg;
    out_shift_next = out_shift_reg;
    sdo_next       = sdo_reg;
    case (state_reg)
      pcb_cfg_pkg::ST_IDLE: begin
        bit_count_next = 4'h0;
        sdo_next       = 1'b0;
        if (cs_active_w) begin
          state_next = pcb_cfg_pkg::ST_HEADER;
        end
      end
      pcb_cfg_pkg::ST_HEADER, pcb_cfg_pkg::ST_DATA: begin
        if (sclk_rise_w) begin
          shift_next     = shift_in_w;
          bit_count_next = bit_count_reg + 4'h1;
        end
        if (header_end_w) begin
          header_next    = shift_in_w[7:0];
          out_shift_next = read_data_w;
          state_next     = pcb_cfg_pkg::ST_DATA;
        end
        if ((state_reg == pcb_cfg_pkg::ST_DATA) && sclk_fall_w && is_read_w) begin
          sdo_next       = out_shift_reg[7];
          out_shift_next = {out_shift_reg[6:0], 1'b0};
        end
        if (frame_end_w) begin
          state_next = enter_off_w ? pcb_cfg_pkg::ST_OFF : pcb_cfg_pkg::ST_WAIT;
        end
        if (!cs_active_w) begin
          state_next = pcb_cfg_pkg::ST_IDLE;
        end
      end
      pcb_cfg_pkg::ST_WAIT: begin
        if (sclk_fall_w && is_read_w) begin
          sdo_next = out_shift_reg[7];
        end
        if (!cs_active_w) begin
          state_next = pcb_cfg_pkg::ST_IDLE;
        end
      end
      pcb_cfg_pkg::ST_OFF: begin
        sdo_next = 1'b0;
        if (sclk_rise_w) begin
          shift_next = shift_in_w;
        end
        if (resume_hit_w) begin
          state_next = pcb_cfg_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = pcb_cfg_pkg::ST_IDLE;
      end
    endcase
    if (hw_reset_w) begin
      state_next = pcb_cfg_pkg::ST_IDLE;
      shift_next = 16'h0000;
    end
  end

  // Register updates.
  always_comb begin
    power_clock_next   = power_clock_reg;
    analog_buffer_next = analog_buffer_reg;
    if (hw_reset_w) begin
      power_clock_next   = pcb_cfg_pkg::POWER_CLOCK_RESET;
      analog_buffer_next = pcb_cfg_pkg::ANALOG_BUFFER_RESET;
    end else if (resume_hit_w) begin
      power_clock_next = power_clock_reg & ~pcb_cfg_pkg::POWER_DOWN_MASK;
    end else begin
      if (power_ok_w) begin
        power_clock_next = power_value_w;
      end
      if (wr_abuf_w) begin
        analog_buffer_next = wdata_w & pcb_cfg_pkg::ANALOG_BUFFER_WMASK;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg         <= pcb_cfg_pkg::ST_IDLE;
      shift_reg         <= 16'h0000;
      bit_count_reg     <= 4'h0;
      header_reg        <= 8'h00;
      out_shift_reg     <= 8'h00;
      sclk_prev_reg     <= 1'b0;
      power_clock_reg   <= pcb_cfg_pkg::POWER_CLOCK_RESET;
      analog_buffer_reg <= pcb_cfg_pkg::ANALOG_BUFFER_RESET;
      core_power_reg    <= pcb_cfg_pkg::PWR_LOW;
      sdo_reg           <= 1'b0;
      sdo_oe_n_reg      <= 1'b1;
    end else begin
      state_reg         <= state_next;
      shift_reg         <= shift_next;
      bit_count_reg     <= bit_count_next;
      header_reg        <= header_next;
      out_shift_reg     <= out_shift_next;
      sclk_prev_reg     <= sclk_w;
      power_clock_reg   <= power_clock_next;
      analog_buffer_reg <= analog_buffer_next;
      core_power_reg    <= core_level(power_clock_next);
      sdo_reg           <= sdo_next;
      sdo_oe_n_reg      <= !(((state_next == pcb_cfg_pkg::ST_DATA) || (state_next == pcb_cfg_pkg::ST_WAIT)) &&
                             header_next[7]);
    end
  end

  // Modulator clock divider, stopped while powered down.
  mod_div_if div_bus ();
  assign div_bus.div_sel = power_clock_reg[pcb_cfg_pkg::DIV_SEL_HI:pcb_cfg_pkg::DIV_SEL_LO];
  assign div_bus.run     = !power_clock_reg[pcb_cfg_pkg::PWR_DOWN_BIT];

  mod_clock_divider u_divider (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .dif     (div_bus)
  );

  // Outputs, each straight from a flip-flop.
  assign spi_sdo                     = sdo_reg;
  assign spi_sdo_oe_n                = sdo_oe_n_reg;
  assign clock_source                = power_clock_reg[pcb_cfg_pkg::CLK_SEL_HI:pcb_cfg_pkg::CLK_SEL_LO];
  assign modulator_frequency         = div_bus.mod_clk;
  assign powered_down                = power_clock_reg[pcb_cfg_pkg::PWR_DOWN_BIT];
  assign raw_modulator_out_enable    = power_clock_reg[pcb_cfg_pkg::RAW_MOD_BIT];
  assign core_power_level            = core_power_reg;
  assign pos_reference_buffering     = analog_buffer_reg[pcb_cfg_pkg::REF_POS_HI:pcb_cfg_pkg::REF_POS_LO];
  assign neg_reference_buffering     = analog_buffer_reg[pcb_cfg_pkg::REF_NEG_HI:pcb_cfg_pkg::REF_NEG_LO];
  assign pos_input_precharge_disable = analog_buffer_reg[pcb_cfg_pkg::AIN_POS_BIT];
  assign neg_input_precharge_disable = analog_buffer_reg[pcb_cfg_pkg::AIN_NEG_BIT];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  AST_CLOCK_SOURCE: assert property (
    (power_ok_w && !hw_reset_w && !resume_hit_w) |=> (clock_source == $past(power_value_w[7:6])))
    else $error("Clock source does not follow the accepted write.");

  AST_PD_DISCARD: assert property (
    (wr_power_w && pd_attempt_w && !pd_exact_w && !hw_reset_w) |=> ($stable(power_clock_reg) && !powered_down))
    else $error("Mixed power-down write was not discarded.");

  AST_PD_ENTER: assert property (
    (enter_off_w && !hw_reset_w) |=> (state_reg == pcb_cfg_pkg::ST_OFF) && powered_down && spi_sdo_oe_n)
    else $error("Exact power-down write did not power down.");

  AST_OFF_QUIET: assert property (
    (state_reg == pcb_cfg_pkg::ST_OFF && !hw_reset_w) |=> ($stable(analog_buffer_reg) && spi_sdo_oe_n))
    else $error("Register changed or port drove while powered down.");

  AST_PD_EXIT: assert property (
    $fell(powered_down) |-> ($past(hw_reset_w) || $past(resume_hit_w)))
    else $error("Power-down left without reset or resume.");

  AST_MOD_LOW: assert property (
    raw_modulator_out_enable |-> (core_power_level == pcb_cfg_pkg::PWR_LOW))
    else $error("Raw modulator output without low power.");

  AST_PWR_FAST: assert property (
    (power_ok_w && !hw_reset_w && !resume_hit_w && !wdata_w[2] && wdata_w[1:0] == 2'b11)
      |=> (core_power_level == pcb_cfg_pkg::PWR_FAST) [*2])
    else $error("Fast power mode not applied.");

  AST_ABUF_WRITE: assert property (
    (wr_abuf_w && !hw_reset_w) |=> ({pos_reference_buffering, neg_reference_buffering,
      pos_input_precharge_disable, neg_input_precharge_disable} == {$past(wdata_w[7:4]), $past(wdata_w[1:0])}))
    else $error("Analog buffer outputs do not match the write.");

  AST_ABUF_RSVD: assert property (
    analog_buffer_reg[3:2] == 2'b00)
    else $error("Reserved buffer bits are not zero.");

  AST_RESET_VALUES: assert property (@(posedge sys_clk) disable iff (1'b0)
    $past(sys_rst) |-> (power_clock_reg == 8'h00 && analog_buffer_reg == 8'h00 && !modulator_frequency))
    else $error("Registers not zero after reset.");

endmodule

// File: tb/spi_host_model.sv
// Host controller model that drives the serial register port of the block.
`timescale 1ns/100ps
module spi_host_model (
  // Clock
  input  wire logic sys_clk,
  // Serial pins
  output logic      cs_n,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe_n
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Each sclk level lasts 5 cycles, above the 4 that the pin filter needs.
  // A released sdo reads as the inverse of its level, so an idle port never passes for read data.
  task automatic xfer(input logic [15:0] word, input logic sel, output logic [7:0] rd);
    rd = 8'h00;
    cs_n = ~sel;
    idle(6);
    for (int i = 15; i >= 0; i--) begin
      sdi = word[i];
      idle(5);
      if (i < 8) rd[i] = (sdo_oe_n === 1'b1) ? ~sdo : sdo;
      sclk = 1'b1;
      idle(5);
      sclk = 1'b0;
    end
    idle(5);
    cs_n = 1'b1;
    sdi  = ~sdi;
    idle(6);
  endtask
endmodule

// File: tb/tb.sv
// Self-checking testbench for the power, clock and buffer configuration block.
`timescale 1ns/100ps
module tb;
  logic       sys_clk;
  logic       sys_rst;
  logic       reset_pin_n;
  wire logic  spi_cs_n;
  wire logic  spi_sclk;
  wire logic  spi_sdi;
  logic       spi_sdo;
  logic       spi_sdo_oe_n;
  logic [1:0] clock_source;
  logic       mod_freq;
  logic       powered_down;
  logic       raw_mod;
  logic [1:0] core_power_level;
  logic [1:0] pos_ref;
  logic [1:0] neg_ref;
  logic       pos_ain_off;
  logic       neg_ain_off;
  int         mismatches;
  int         total_checks;
  int         cycles;
  logic [7:0] rd;

  power_clock_buffer_config power_clock_buffer_config_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
    .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe_n(spi_sdo_oe_n),
    .clock_source(clock_source), .modulator_frequency(mod_freq), .powered_down(powered_down),
    .raw_modulator_out_enable(raw_mod), .core_power_level(core_power_level),
    .pos_reference_buffering(pos_ref), .neg_reference_buffering(neg_ref),
    .pos_input_precharge_disable(pos_ain_off), .neg_input_precharge_disable(neg_ain_off));

  spi_host_model spi_host_model_i (
    .sys_clk(sys_clk), .cs_n(spi_cs_n), .sclk(spi_sclk), .sdi(spi_sdi), .sdo(spi_sdo), .sdo_oe_n(spi_sdo_oe_n));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Ceiling is between three and four times the expected length of the run.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    spi_host_model_i.xfer({1'b0, a, d}, 1'b1, rd);
  endtask

  task automatic rd_frame(input logic [6:0] a);
    spi_host_model_i.xfer({1'b1, a, 8'h00}, 1'b1, rd);
  endtask

  // Counts cycles between two rising edges of the modulator clock; 0 if it does not run.
  task automatic mod_period(output logic [7:0] n);
    int c;
    logic p;
    c = 0;
    n = 8'h00;
    p = 1'b1;
    for (int k = 0; k < 100; k++) begin
      @(negedge sys_clk);
      if (!p && mod_freq) begin
        if (c != 0) begin
          n = 8'(k - c);
          break;
        end
        c = k;
      end
      p = mod_freq;
    end
  endtask

  task automatic t_reset();
    check({clock_source, 1'b0, powered_down, raw_mod, 1'b0, core_power_level}, 8'h00);
    check({pos_ref, neg_ref, 2'b00, pos_ain_off, neg_ain_off}, 8'h00);
    rd_frame(pcb_cfg_pkg::ADDR_POWER_CLOCK);
    check(rd, pcb_cfg_pkg::POWER_CLOCK_RESET);
    rd_frame(pcb_cfg_pkg::ADDR_ANALOG_BUFFER);
    check(rd, pcb_cfg_pkg::ANALOG_BUFFER_RESET);
  endtask

  task automatic t_clock();
    logic [7:0] d;
    logic [7:0] n;
    for (int v = 0; v < 4; v++) begin
      d = {v[1:0], v[1:0], 2'b00, v[1:0]};
      wr(pcb_cfg_pkg::ADDR_POWER_CLOCK, d);
      check({6'h00, clock_source}, {6'h00, v[1:0]});
      check({6'h00, core_power_level}, (v == 1) ? 8'h00 : 8'(v));
      mod_period(n);
      check(n, 8'(16 >> v));
      rd_frame(pcb_cfg_pkg::ADDR_POWER_CLOCK);
      check(rd, d);
    end
  endtask

  task automatic t_raw_guard();
    wr(pcb_cfg_pkg::ADDR_POWER_CLOCK, 8'h03);
    wr(pcb_cfg_pkg::ADDR_POWER_CLOCK, 8'h06);
    check({6'h00, raw_mod, core_power_level[1]}, 8'h02);
    check({7'h00, core_power_level[0]}, 8'h00);
    rd_frame(pcb_cfg_pkg::ADDR_POWER_CLOCK);
    check(rd, 8'h07);
    wr(pcb_cfg_pkg::ADDR_POWER_CLOCK, 8'h8c);
    check({7'h00, powered_down}, 8'h00);
    rd_frame(pcb_cfg_pkg::ADDR_POWER_CLOCK);
    check(rd, 8'h07);
  endtask

  task automatic t_buffer();
    logic [7:0] v;
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 8'hff : 8'h64;
      wr(pcb_cfg_pkg::ADDR_ANALOG_BUFFER, v);
      check({6'h00, pos_ref}, {6'h00, v[7:6]});
      check({6'h00, neg_ref}, {6'h00, v[5:4]});
      check({7'h00, pos_ain_off}, {7'h00, v[1]});
      check({7'h00, neg_ain_off}, {7'h00, v[0]});
      rd_frame(pcb_cfg_pkg::ADDR_ANALOG_BUFFER);
      check(rd, v & 8'hf3);
    end
    wr(7'h17, 8'h5a);
    rd_frame(7'h17);
    check(rd, 8'h00);
  endtask

  task automatic t_power_down();
    logic [7:0] n;
    wr(pcb_cfg_pkg::ADDR_POWER_CLOCK, pcb_cfg_pkg::POWER_DOWN_ONLY);
    check({7'h00, powered_down}, 8'h01);
    mod_period(n);
    check(n, 8'h00);
    wr(pcb_cfg_pkg::ADDR_ANALOG_BUFFER, 8'h00);
    rd_frame(pcb_cfg_pkg::ADDR_ANALOG_BUFFER);
    check(rd, 8'hff);
    spi_host_model_i.xfer(pcb_cfg_pkg::RESUME_WORD, 1'b0, rd);
    check({7'h00, powered_down}, 8'h00);
    rd_frame(pcb_cfg_pkg::ADDR_ANALOG_BUFFER);
    check(rd, 8'h60);
    wr(pcb_cfg_pkg::ADDR_POWER_CLOCK, pcb_cfg_pkg::POWER_DOWN_ONLY);
    reset_pin_n = 1'b0;
    spi_host_model_i.idle(8);
    reset_pin_n = 1'b1;
    spi_host_model_i.idle(8);
    check({7'h00, powered_down}, 8'h00);
    rd_frame(pcb_cfg_pkg::ADDR_ANALOG_BUFFER);
    check(rd, 8'h00);
    // A power cycle is the third way out of power-down.
    wr(pcb_cfg_pkg::ADDR_POWER_CLOCK, pcb_cfg_pkg::POWER_DOWN_ONLY);
    check({7'h00, powered_down}, 8'h01);
    sys_rst = 1'b1;
    spi_host_model_i.idle(4);
    sys_rst = 1'b0;
    spi_host_model_i.idle(6);
    check({7'h00, powered_down}, 8'h00);
    rd_frame(pcb_cfg_pkg::ADDR_POWER_CLOCK);
    check(rd, pcb_cfg_pkg::POWER_CLOCK_RESET);
  endtask

  initial begin
    sys_rst = 1'b1;
    reset_pin_n = 1'b1;
    mismatches = 0;
    total_checks = 0;
    cycles = 0;
    repeat (20) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (6) @(negedge sys_clk);
    t_reset();
    t_clock();
    t_raw_guard();
    t_buffer();
    t_power_down();
    final_report();
  end
endmodule
